/* File: inc/rpm_regs.svh */
`ifndef RPM_REGS_SVH
`define RPM_REGS_SVH
// Function
// RL1: brownout resets core, or interrupts if configured
// RL2: software switches brownout detection on and off
// RL3: brownout condition follows the supply comparator
// RL4: power-up sets power-on flag until cleared
// RL5: idle halts core; interrupt or reset ends it
// RL6: power-down stops oscillator; reset or wake irq exits
// RL7: brownout, watchdog, comparators, timer run in power-down
// RL8: rc oscillator off unless sysclk and timer enabled
// RL9: total power-down also kills brownout and comparators
// RL10: pin enable selects reset input or digital input
// RL11: power-up forces pin reset; nothing else overrides
// RL12: six reset sources are accepted
// RL13: one flag per source; writing zero clears
// RL14: power-on sets power-on and brownout, clears rest
// RL15: other resets set own flag, keep others
// RL16: fetch from zero or boot vector page
// RL17: boot address after break, boot bit, forced isp
// RL18: low supply systems leave brownout config unprogrammed
// RL19: wake via reset after lowering to retention supply
// RL20: do not hold reset pin low at power-on
// RL21: enabled external interrupt wakes from idle, power-down
// RL22: wake restarts oscillator, waits until stable

// ----------------------------------------------------------
// timing
// ----------------------------------------------------------
`define RPM_CLK_NS 40
`define RPM_OSC_STAB_NS 2000
`define RPM_RST_HOLD_NS 1000
`define RPM_OSC_CYC \
  ((`RPM_OSC_STAB_NS + `RPM_CLK_NS - 1) / `RPM_CLK_NS)
`define RPM_HOLD_CYC \
  ((`RPM_RST_HOLD_NS + `RPM_CLK_NS - 1) / `RPM_CLK_NS)

// ----------------------------------------------------------
// register map (byte offsets)
// ----------------------------------------------------------
`define RPM_OFF_RSRC 4'h0
`define RPM_OFF_CTRL 4'h4
`define RPM_OFF_STAT 4'h8

// reset source flag bits
`define RPM_NFLAG 6
`define RPM_F_POF 0
`define RPM_F_BOF 1
`define RPM_F_EXT 2
`define RPM_F_WDT 3
`define RPM_F_SWR 4
`define RPM_F_BRK 5
`define RPM_FLAGS_POR 6'h03

// control bits
`define RPM_C_BOE 0
`define RPM_C_BOI 1
`define RPM_C_SWR 2
`define RPM_C_MODE 3
`define RPM_C_RCSEL 5
`define RPM_C_RTCEN 6
`define RPM_C_CMPOFF 7
`define RPM_CTRL_RST 8'h01
`define RPM_CTRL_MASK 8'hE3

// status fields
`define RPM_S_MODE 0
`define RPM_S_BOD 3
`define RPM_S_OSC 4
`define RPM_S_PIN 5
`define RPM_S_VEC 8

`define RPM_BOOT_LO 8'h00
`define RPM_VEC_ZERO 16'h0000
`endif

/* File: inc/rpm_pkg.sv */
package rpm_pkg;
  `include "rpm_regs.svh"

  typedef logic [15:0] rpm_vec_type;

  typedef enum logic [2:0] {
    RPM_RUN = 3'b000,
    RPM_IDLE = 3'b001,
    RPM_PDN = 3'b010,
    RPM_TPD = 3'b011,
    RPM_WAKE = 3'b100
  } rpm_mode_type;

  typedef struct packed {
    rpm_mode_type mode;
    logic [`RPM_NFLAG-1:0] flags;
    logic [7:0] ctrl;
    logic swr;
    logic ack;
    logic [31:0] dat;
    rpm_vec_type vec;
    logic in_rst;
    logic cur_brk;
    logic cur_por;
  } rpm_state_type;
endpackage : rpm_pkg

/* File: inc/rpm_cnt_if.sv */
`timescale 1ns/1ns
interface rpm_cnt_if;
  logic start;
  logic busy;
  modport ctl (output start, input busy);
  modport cnt (input start, output busy);
endinterface : rpm_cnt_if

/* File: logic/rpm_sync.sv */
`timescale 1ns/1ns
module rpm_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] INIT = '0
) (
  input logic clk_i,
  input logic rst_i,
  input logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  import rpm_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } rpm_sync_st_type;

  rpm_sync_st_type r;
  rpm_sync_st_type next_r;

  // two stages; only s2 leaves the module
  always_comb
  begin
    next_r.s1 = d_i;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      r <= {INIT, INIT};
    else
      r <= next_r;
  end

  assign q_o = r.s2;
endmodule : rpm_sync

/* File: logic/rpm_delay.sv */
`timescale 1ns/1ns
module rpm_delay #(
  parameter int CYC = 50
) (
  input logic clk_i,
  input logic rst_i,
  rpm_cnt_if.cnt ci
);
  import rpm_pkg::*;

  localparam int W = $clog2(CYC + 1);
  localparam logic [W-1:0] LOAD = W'(CYC);

  typedef struct packed {
    logic [W-1:0] cnt;
  } rpm_dly_st_type;

  rpm_dly_st_type r;
  rpm_dly_st_type next_r;

  // start reloads, so a held start keeps it busy
  always_comb
  begin
    next_r = r;
    if (ci.start)
      next_r.cnt = LOAD;
    else if (r.cnt != '0)
      next_r.cnt = r.cnt - W'(1);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      r <= '0;
    else
      r <= next_r;
  end

  assign ci.busy = (r.cnt != '0);
endmodule : rpm_delay

/* File: logic/rpm_top.sv */
// Added by the designer: register access over Wishbone and the register addresses.
`timescale 1ns/1ns
module rpm_top (
  input logic clk_i,
  input logic rst_i,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [3:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input logic por_det_i,
  input logic bod_below_i,
  input logic shared_port_pin_i,
  input logic wdt_rst_i,
  input logic uart_break_i,
  input logic reset_pin_enable_i,
  input logic brownout_enable_config_i,
  input logic [7:0] boot_status_byte_i,
  input logic [7:0] boot_vector_i,
  input logic isp_force_i,
  input logic irq_pending_i,
  input logic wake_irq_i,
  output logic core_rst_o,
  output rpm_pkg::rpm_vec_type reset_vector_o,
  output logic bod_irq_o,
  output logic core_halt_o,
  output logic osc_en_o,
  output logic periph_run_o,
  output logic rc_osc_en_o,
  output logic bod_power_o,
  output logic cmp_power_o,
  output logic wdt_run_o,
  output logic rtc_run_o,
  output logic port_pin_o
);
  import rpm_pkg::*;

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  // word decode, low two address bits ignored
  function automatic logic hit(
    input logic [3:0] adr,
    input logic [3:0] off
  );
    hit = (adr[3:2] == off[3:2]);
  endfunction : hit

  rpm_state_type r;
  rpm_state_type next_r;

  // ----------------------------------------------------------
  // pin and detector synchronisers
  // ----------------------------------------------------------
  logic [2:0] raw_in;
  logic [2:0] syn;
  logic por_s;
  logic bod_s;
  logic pin_s;

  assign raw_in = {shared_port_pin_i, bod_below_i, por_det_i};

  // pin idles high so reset does not fake a pin reset
  rpm_sync #(
    .W(3),
    .INIT(3'h4)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(raw_in),
    .q_o(syn)
  );

  assign por_s = syn[0];
  assign bod_s = syn[1];
  assign pin_s = syn[2];

  // ----------------------------------------------------------
  // reset stretch and oscillator settle counters
  // ----------------------------------------------------------
  rpm_cnt_if hold_if ();
  rpm_cnt_if osc_if ();

  rpm_delay #(
    .CYC(`RPM_HOLD_CYC)
  ) u_hold (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ci(hold_if.cnt)
  );

  rpm_delay #(
    .CYC(`RPM_OSC_CYC)
  ) u_osc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ci(osc_if.cnt)
  );

  // ----------------------------------------------------------
  // brownout
  // ----------------------------------------------------------
  logic bod_en;
  logic bod_act;
  logic bod_rst;
  logic in_tpd;

  assign in_tpd = (r.mode == RPM_TPD);
  // software enable gated by the fused configuration
  assign bod_en = r.ctrl[`RPM_C_BOE] & brownout_enable_config_i;
  // condition tracks the comparator level [RL3]
  assign bod_act = bod_s & bod_en & ~in_tpd; // [RL2] [RL9]
  // reset by default, interrupt request when selected [RL1]
  assign bod_rst = bod_act & ~r.ctrl[`RPM_C_BOI];
  assign bod_irq_o = bod_act & r.ctrl[`RPM_C_BOI];

  // ----------------------------------------------------------
  // reset sources
  // ----------------------------------------------------------
  logic powerup;
  logic ext_req;
  logic [`RPM_NFLAG-1:0] src;
  logic rst_any;
  logic core_rst;

  // power-up window lasts through the stretch of a por
  assign powerup = por_s | (r.cur_por & r.in_rst);
  // pin reset only if enabled, or while powering up [RL10] [RL11]
  assign ext_req = ~pin_s & (reset_pin_enable_i | powerup);

  // one bit per accepted source [RL12]
  always_comb
  begin
    src = '0;
    src[`RPM_F_POF] = por_s;
    src[`RPM_F_BOF] = bod_rst;
    src[`RPM_F_EXT] = ext_req;
    src[`RPM_F_WDT] = wdt_rst_i;
    src[`RPM_F_SWR] = r.swr;
    src[`RPM_F_BRK] = uart_break_i;
  end

  assign rst_any = |src;
  assign hold_if.start = rst_any;
  // stretched so short pulses still give a full reset
  assign core_rst = rst_i | rst_any | hold_if.busy;
  assign core_rst_o = core_rst;

  // ----------------------------------------------------------
  // register bus
  // ----------------------------------------------------------
  logic req;
  logic wr;
  logic [31:0] rd_word;
  logic [`RPM_NFLAG-1:0] clr;
  logic [1:0] mode_req;

  assign req = wb_cyc_i & wb_stb_i;
  // writes land on the edge where ack is sampled
  assign wr = req & wb_we_i & r.ack & wb_sel_i[0];

  // read mux; unmapped words read zero
  always_comb
  begin
    rd_word = '0;
    if (hit(wb_adr_i, `RPM_OFF_RSRC))
      rd_word[`RPM_NFLAG-1:0] = r.flags;
    else if (hit(wb_adr_i, `RPM_OFF_CTRL))
      rd_word[7:0] = r.ctrl;
    else if (hit(wb_adr_i, `RPM_OFF_STAT))
    begin
      rd_word[`RPM_S_MODE +: 3] = r.mode;
      rd_word[`RPM_S_BOD] = bod_s;
      rd_word[`RPM_S_OSC] = osc_en_o;
      rd_word[`RPM_S_PIN] = port_pin_o;
      rd_word[`RPM_S_VEC +: 16] = r.vec;
    end
  end

  // writing zero clears a flag, ones leave it alone [RL13]
  assign clr = (wr && hit(wb_adr_i, `RPM_OFF_RSRC)) ?
    ~wb_dat_i[`RPM_NFLAG-1:0] : '0;
  assign mode_req = (wr && hit(wb_adr_i, `RPM_OFF_CTRL)) ?
    wb_dat_i[`RPM_C_MODE +: 2] : 2'h0;

  // ----------------------------------------------------------
  // next state
  // ----------------------------------------------------------
  logic boot_sel;

  always_comb
  begin
    next_r = r;
    boot_sel = 1'b0;
    // one wait state, ack drops the cycle after
    next_r.ack = req & ~r.ack;
    if (req && !r.ack)
      next_r.dat = rd_word;
    // software reset is a one-cycle request
    next_r.swr = 1'b0;
    if (wr && hit(wb_adr_i, `RPM_OFF_CTRL))
    begin
      next_r.ctrl = wb_dat_i[7:0] & `RPM_CTRL_MASK;
      next_r.swr = wb_dat_i[`RPM_C_SWR];
    end

    // flags: por wipes, otherwise set beats clear
    if (por_s)
      next_r.flags = `RPM_FLAGS_POR; // [RL4] [RL14]
    else
      next_r.flags = (r.flags & ~clr) | src; // [RL15]

    // remember what started this reset episode
    next_r.in_rst = core_rst;
    if (rst_any && !r.in_rst)
    begin
      next_r.cur_brk = src[`RPM_F_BRK];
      next_r.cur_por = src[`RPM_F_POF];
    end
    else if (rst_any)
    begin
      next_r.cur_brk = r.cur_brk | src[`RPM_F_BRK];
      next_r.cur_por = r.cur_por | src[`RPM_F_POF];
    end

    // vector tracks during reset, frozen at release [RL17]
    boot_sel = next_r.cur_brk | boot_status_byte_i[0] |
      (next_r.cur_por & isp_force_i);
    if (core_rst)
      next_r.vec = boot_sel ?
        {boot_vector_i, `RPM_BOOT_LO} : `RPM_VEC_ZERO; // [RL16]

    // power mode sequencing
    unique case (r.mode)
      RPM_RUN:
      begin
        if (mode_req != 2'h0)
          next_r.mode = rpm_mode_type'({1'b0, mode_req});
      end
      RPM_IDLE:
      begin
        if (irq_pending_i)
          next_r.mode = RPM_RUN; // [RL5] [RL21]
      end
      RPM_PDN, RPM_TPD:
      begin
        if (wake_irq_i)
          next_r.mode = RPM_WAKE; // [RL6] [RL21]
      end
      RPM_WAKE:
      begin
        if (!osc_if.busy)
          next_r.mode = RPM_RUN; // [RL22]
      end
      default:
        next_r.mode = RPM_RUN;
    endcase
    // any reset ends every low-power mode [RL5] [RL6]
    if (core_rst)
      next_r.mode = RPM_RUN;
  end

  // oscillator settle timer kicked on wake request [RL22]
  assign osc_if.start = ((r.mode == RPM_PDN) || in_tpd) &
    wake_irq_i & ~core_rst;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r <= '0;
      r.mode <= RPM_RUN;
      r.flags <= `RPM_FLAGS_POR;
      r.ctrl <= `RPM_CTRL_RST;
      r.in_rst <= 1'b1;
      r.cur_por <= 1'b1;
    end
    else
      r <= next_r;
  end

  // ----------------------------------------------------------
  // outputs
  // ----------------------------------------------------------
  logic pdn_any;

  assign pdn_any = (r.mode == RPM_PDN) || in_tpd;
  assign wb_ack_o = r.ack;
  assign wb_dat_o = r.dat;
  assign reset_vector_o = r.vec;
  assign core_halt_o = (r.mode != RPM_RUN); // [RL5]
  assign osc_en_o = ~pdn_any; // [RL6]
  // peripherals stop only with the oscillator
  assign periph_run_o = ~pdn_any; // [RL5]
  // rc oscillator survives power-down only as timer clock [RL8]
  assign rc_osc_en_o = r.ctrl[`RPM_C_RCSEL] &
    (~pdn_any | r.ctrl[`RPM_C_RTCEN]);
  assign bod_power_o = bod_en & ~in_tpd; // [RL7] [RL9]
  assign cmp_power_o = ~r.ctrl[`RPM_C_CMPOFF] & ~in_tpd;
  // watchdog has its own oscillator, never gated here [RL7]
  assign wdt_run_o = 1'b1;
  assign rtc_run_o = r.ctrl[`RPM_C_RTCEN]; // [RL7]
  // reads high while the pin serves as reset input [RL10]
  assign port_pin_o = reset_pin_enable_i | pin_s;

  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  localparam int WAKE_MAX = `RPM_OSC_CYC + 2;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_enter_wake;
    pdn_any && wake_irq_i && !core_rst;
  endsequence

  sequence s_back_run;
    (r.mode == RPM_RUN) && !core_halt_o;
  endsequence

  por_flags_a: assert property ( // [RL14]
    por_s |=> (r.flags == `RPM_FLAGS_POR))
    else $error("por did not set exactly por and brownout flags");

  flag_clear_a: assert property ( // [RL13]
    clr[`RPM_F_WDT] && !wdt_rst_i && !por_s
    |=> !r.flags[`RPM_F_WDT])
    else $error("writing zero did not clear watchdog flag");

  flag_keep_a: assert property ( // [RL15]
    !por_s && r.flags[`RPM_F_EXT] && !clr[`RPM_F_EXT]
    |=> r.flags[`RPM_F_EXT])
    else $error("uncleared flag lost on other reset");

  set_wins_a: assert property ( // [RL15]
    wdt_rst_i && !por_s |=> r.flags[`RPM_F_WDT])
    else $error("watchdog reset flag not set");

  bod_mode_a: assert property ( // [RL1]
    bod_s && bod_en && !in_tpd
    |-> (bod_irq_o != core_rst_o) || core_rst_o)
    else $error("brownout neither reset nor interrupt");

  bod_off_a: assert property ( // [RL2]
    !bod_en |-> !bod_irq_o && !src[`RPM_F_BOF])
    else $error("disabled brownout had effect");

  tpd_power_a: assert property ( // [RL9]
    in_tpd |-> !bod_power_o && !cmp_power_o && !bod_irq_o)
    else $error("total power-down left detectors on");

  pin_gate_a: assert property ( // [RL11]
    !reset_pin_enable_i && !powerup |-> !ext_req)
    else $error("pin reset while disabled");

  idle_exit_a: assert property ( // [RL5]
    (r.mode == RPM_IDLE) && irq_pending_i
    |=> (r.mode == RPM_RUN))
    else $error("idle not ended by interrupt");

  pdn_osc_a: assert property ( // [RL6]
    pdn_any |-> !osc_en_o && core_halt_o)
    else $error("oscillator running in power-down");

  wake_seq_a: assert property ( // [RL22]
    s_enter_wake |=> osc_en_o && core_halt_o ##1
    (core_halt_o throughout osc_if.busy[*2]) ##0
    (1'b1 ##[1:WAKE_MAX] s_back_run))
    else $error("wake did not settle oscillator then resume");

  vec_boot_a: assert property ( // [RL17]
    $fell(core_rst_o) && r.cur_brk
    |-> reset_vector_o == {boot_vector_i, `RPM_BOOT_LO})
    else $error("break reset did not select boot address");

  rst_mode_a: assert property ( // [RL6]
    core_rst && pdn_any |=> (r.mode == RPM_RUN))
    else $error("reset did not end power-down");
endmodule : rpm_top

/* File: dv/rpm_far_model.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------
// supply detectors and external reset pin
// ----------------------------------------------------------
module rpm_far_model #(
  parameter int PWR_CYC = 10
) (
  input wire logic clk_i,
  input wire logic power_up_i,
  input wire logic supply_low_i,
  input wire logic pin_low_i,
  output logic por_det_o,
  output logic bod_below_o,
  output logic pin_o
);
  int cnt = 0;

  // detector stays high while the supply ramps up
  always @(posedge clk_i)
  begin
    if (power_up_i)
      cnt <= PWR_CYC;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end

  // ramping supply is also below the trip level
  assign por_det_o = power_up_i || cnt > 0;
  assign bod_below_o = supply_low_i || por_det_o;
  // pin is never held low while power comes up
  assign pin_o = !(pin_low_i && !por_det_o);
endmodule : rpm_far_model

/* File: dv/test_reset_and_power_mode_control.sv */
`timescale 1ns/1ns
`include "rpm_regs.svh"
// ----------------------------------------------------------
// bench
// ----------------------------------------------------------
module test_reset_and_power_mode_control;
  import rpm_pkg::*;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [2:0] mode;
    logic [5:0] outs;
  } rpm_row_type;
  logic clk_i = 0, rst_i = 1;
  logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
  logic [3:0] wb_adr_i = '0, wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o, rdat;
  logic por_det_i, bod_below_i, shared_port_pin_i;
  logic wdt_rst_i = 0, uart_break_i = 0, reset_pin_enable_i = 1;
  logic brownout_enable_config_i = 1, isp_force_i = 0;
  logic [7:0] boot_status_byte_i = '0, boot_vector_i = 8'h5A;
  logic irq_pending_i = 0, wake_irq_i = 0;
  logic power_up = 1, supply_low = 0, pin_low = 0;
  logic core_rst_o, bod_irq_o, core_halt_o, osc_en_o, periph_run_o;
  logic rc_osc_en_o, bod_power_o, cmp_power_o, wdt_run_o, rtc_run_o;
  logic port_pin_o;
  rpm_vec_type reset_vector_o;
  int num_errors = 0, checks_done = 0;
  // control value, mode, {halt,osc,periph,rc,bod,cmp}
  rpm_row_type rows [8] = '{{8'h09, 3'h1, 6'h3B}, {8'h29, 3'h1, 6'h3F},
    {8'h11, 3'h2, 6'h23}, {8'h71, 3'h2, 6'h27}, {8'h31, 3'h2, 6'h23},
    {8'h19, 3'h3, 6'h20}, {8'hF9, 3'h3, 6'h24}, {8'h91, 3'h2, 6'h22}};

  // 25 MHz
  always #20 clk_i = ~clk_i;

  // ----------------------------------------------------------
  // design and far side
  // ----------------------------------------------------------
  rpm_top rpm_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .por_det_i(por_det_i), .bod_below_i(bod_below_i),
    .shared_port_pin_i(shared_port_pin_i), .wdt_rst_i(wdt_rst_i),
    .uart_break_i(uart_break_i), .reset_pin_enable_i(reset_pin_enable_i),
    .brownout_enable_config_i(brownout_enable_config_i),
    .boot_status_byte_i(boot_status_byte_i), .boot_vector_i(boot_vector_i),
    .isp_force_i(isp_force_i), .irq_pending_i(irq_pending_i),
    .wake_irq_i(wake_irq_i), .core_rst_o(core_rst_o),
    .reset_vector_o(reset_vector_o), .bod_irq_o(bod_irq_o),
    .core_halt_o(core_halt_o), .osc_en_o(osc_en_o),
    .periph_run_o(periph_run_o), .rc_osc_en_o(rc_osc_en_o),
    .bod_power_o(bod_power_o), .cmp_power_o(cmp_power_o),
    .wdt_run_o(wdt_run_o), .rtc_run_o(rtc_run_o), .port_pin_o(port_pin_o));

  rpm_far_model rpm_far_model_i (.clk_i(clk_i), .power_up_i(power_up),
    .supply_low_i(supply_low), .pin_low_i(pin_low), .por_det_o(por_det_i),
    .bod_below_o(bod_below_i), .pin_o(shared_port_pin_i));

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic hang();
    num_errors++;
    wrap_up();
  endtask : hang

  task automatic cyc_wait(input int c);
    repeat (c) @(posedge clk_i);
    @(negedge clk_i);
  endtask : cyc_wait

  // one classic cycle; ack and data taken at the rising edge, released there
  task automatic wb(input logic w, input logic [3:0] a,
    input logic [31:0] d);
    int n;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1)
        break;
    end
    if (n == 20)
      hang();
    rdat = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
  endtask : wb

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check(rdat, e);
  endtask : rd_chk

  // waits for core reset (1) or halt (0) to drop, bounded
  task automatic settle(input logic rst_sel);
    int n;
    for (n = 0; n < 300; n++)
    begin
      @(posedge clk_i);
      if ((rst_sel ? core_rst_o : core_halt_o) === 1'b0)
        break;
    end
    if (n == 300)
      hang();
  endtask : settle

  // raise one source for a few cycles: 0 wdt, 1 break, 2 pin, 3 supply
  task automatic kick(input int k, input logic er, input logic ei);
    @(posedge clk_i);
    case (k)
      0: wdt_rst_i <= 1;
      1: uart_break_i <= 1;
      2: pin_low <= 1;
      default: supply_low <= 1;
    endcase
    cyc_wait(4);
    check(core_rst_o, er);
    check(bod_irq_o, ei);
    if (k == 2)
      check(port_pin_o, reset_pin_enable_i);
    @(posedge clk_i);
    {wdt_rst_i, uart_break_i, pin_low, supply_low} <= 4'h0;
    // let the released pin or comparator clear the synchroniser first
    cyc_wait(3);
    settle(1'b1);
  endtask : kick

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    power_up <= 0;
    // synced power-on detect arrives two edges after release
    cyc_wait(3);
    check(core_rst_o, 1'b1);
    settle(1'b1);
    rd_chk(`RPM_OFF_RSRC, 32'h03);
    rd_chk(`RPM_OFF_STAT, 32'h30);
    check(32'(reset_vector_o), 32'h0);
    rd_chk(4'hC, 32'h0);
    foreach (rows[i])
    begin
      wb(1'b1, `RPM_OFF_CTRL, 32'(rows[i].ctrl));
      cyc_wait(2);
      check(32'({core_halt_o, osc_en_o, periph_run_o, rc_osc_en_o,
        bod_power_o, cmp_power_o}), 32'(rows[i].outs));
      check({wdt_run_o, rtc_run_o}, {1'b1, rows[i].ctrl[6]});
      wb(1'b0, `RPM_OFF_STAT, 32'h0);
      check(rdat[2:0], rows[i].mode);
      @(posedge clk_i);
      if (rows[i].mode == 3'h1)
        irq_pending_i <= 1;
      else
        wake_irq_i <= 1;
      if (rows[i].mode != 3'h1)
      begin
        cyc_wait(10);
        check({core_halt_o, osc_en_o}, 2'h3);
      end
      settle(1'b0);
      check(osc_en_o, 1'b1);
      @(posedge clk_i);
      {irq_pending_i, wake_irq_i} <= 2'h0;
    end
    wb(1'b1, `RPM_OFF_RSRC, 32'h0);
    rd_chk(`RPM_OFF_RSRC, 32'h0);
    kick(0, 1, 0);
    rd_chk(`RPM_OFF_RSRC, 32'h08);
    wb(1'b1, `RPM_OFF_CTRL, 32'h05);
    cyc_wait(1);
    check(core_rst_o, 1'b1);
    settle(1'b1);
    rd_chk(`RPM_OFF_RSRC, 32'h18);
    kick(2, 1, 0);
    rd_chk(`RPM_OFF_RSRC, 32'h1C);
    reset_pin_enable_i <= 0;
    kick(2, 0, 0);
    reset_pin_enable_i <= 1;
    kick(3, 1, 0);
    rd_chk(`RPM_OFF_RSRC, 32'h1E);
    wb(1'b1, `RPM_OFF_CTRL, 32'h03);
    kick(3, 0, 1);
    wb(1'b1, `RPM_OFF_CTRL, 32'h00);
    kick(3, 0, 0);
    wb(1'b1, `RPM_OFF_CTRL, 32'h01);
    brownout_enable_config_i <= 0;
    kick(3, 0, 0);
    brownout_enable_config_i <= 1;
    wb(1'b1, `RPM_OFF_RSRC, 32'h0);
    kick(1, 1, 0);
    rd_chk(`RPM_OFF_RSRC, 32'h20);
    check(32'(reset_vector_o), 32'h5A00);
    boot_status_byte_i <= 8'h01;
    kick(0, 1, 0);
    check(32'(reset_vector_o), 32'h5A00);
    boot_status_byte_i <= 8'h00;
    wb(1'b1, `RPM_OFF_CTRL, 32'h09);
    kick(0, 1, 0);
    check(core_halt_o, 1'b0);
    check(32'(reset_vector_o), 32'h0);
    // supply sag in power-down wakes the core through a reset
    wb(1'b1, `RPM_OFF_CTRL, 32'h11);
    kick(3, 1, 0);
    check(core_halt_o, 1'b0);
    check(osc_en_o, 1'b1);
    isp_force_i <= 1;
    @(posedge clk_i);
    power_up <= 1;
    @(posedge clk_i);
    power_up <= 0;
    cyc_wait(3);
    check(core_rst_o, 1'b1);
    settle(1'b1);
    rd_chk(`RPM_OFF_RSRC, 32'h03);
    check(32'(reset_vector_o), 32'h5A00);
    wrap_up();
  end
endmodule : test_reset_and_power_mode_control
